// ==== hw/cpe_event_select.sv ====
// Contract
// - twin-line selection comes from event-select bits 9..7.
// - twin codes: 001 lookup, 010 miss, 011 hit one, 100 hit both.
// - count when active directory levels satisfy compare against threshold 0..31.
// - active-level threshold and compare sit in bits 16..10.
// - directory access type selected by bits 19..17.
// - access codes: 001 sram update, 010 sram read, 100 ipt read, 101 elected.
// - direction bits 64..63: incoming, outgoing, tracker output, lookup response.
// - all traffic match fields live in bits 64..20.
// - incoming compares requester home node under mask; zero mask matches all.
// - outgoing compares destination node under mask; zero mask matches all.
// - message class and opcode each compared under their own mask.
// - tracker output counts on selected state and any enabled response type.
// - events sourced from local agents, remote agents, or both.
// - source select: both 111111110, local 111100000, remote 000011110.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module cpe_event_select (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cpe_pkg::cpe_axi_req_t axiReq,
  output cpe_pkg::cpe_axi_rsp_t axiRsp,
  input wire cpe_pkg::cpe_agent_evt_t [cpe_pkg::NAGENT-1:0] agentEvt,
  output logic countPulse
);
  import cpe_pkg::*;

  logic [SEL_W-1:0] sel_q;
  logic [8:0] src_q;
  logic trafEn_q;
  logic [31:0] pulseTotal_q;
  logic countPulse_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wrTake;
  logic rdTake;
  logic [31:0] rdWord;
  logic rdOk;
  logic wrOk;

  // decoded fields
  logic [2:0] twinSel;
  logic [4:0] lvlThr;
  logic [1:0] lvlCmp;
  logic [2:0] accSel;
  logic [1:0] dirSel;
  logic [3:0] mcSel;
  logic [3:0] mcmSel;
  logic [3:0] ocSel;
  logic [3:0] ocmSel;
  logic [4:0] nidSel;
  logic [4:0] nidmSel;
  logic [4:0] lstSel;
  logic [1:0] tosSel;
  logic [9:0] torSel;
  logic [NAGENT-1:0] agentEn;
  wire [NAGENT-1:0] twinHitV;
  wire [NAGENT-1:0] lvlHitV;
  wire [NAGENT-1:0] accHitV;
  wire [NAGENT-1:0] trafHitV;
  wire [NAGENT-1:0] agentHit;

  assign twinSel = sel_q[TWIN_LSB +: 3];
  assign lvlThr = sel_q[LVL_THR_LSB +: 5];
  assign lvlCmp = sel_q[LVL_CMP_LSB +: 2];
  assign accSel = sel_q[ACC_LSB +: 3];
  assign dirSel = sel_q[DIR_LSB +: 2];
  assign mcSel = sel_q[MC_LSB +: 4];
  assign mcmSel = sel_q[MCM_LSB +: 4];
  assign ocSel = sel_q[OC_LSB +: 4];
  assign ocmSel = sel_q[OCM_LSB +: 4];
  assign nidSel = sel_q[NID_LSB +: 5];
  assign nidmSel = sel_q[NODE_IDENTIFIER_MASK_LSB +: 5];
  assign lstSel = sel_q[LST_LSB +: 5];
  assign tosSel = sel_q[TOS_LSB +: 2];
  assign torSel = sel_q[TOR_LSB +: 10];
  // bit 0 of the source select has no agent behind it
  assign agentEn = src_q[NAGENT:1];

  for (genvar i = 0; i < NAGENT; i++) begin : g_agent
    cpe_agent_evt_t e;
    logic twinHit;
    logic lvlHit;
    logic mcOk;
    logic ocOk;
    logic nodeOk;
    logic dirHit;
    logic [4:0] node;
    assign e = agentEvt[i];

    always_comb begin
      case (twinSel)
        TWIN_LOOKUP: twinHit = e.twinLookup;
        TWIN_MISS: twinHit = e.twinMiss;
        TWIN_HIT_ONE: twinHit = e.twinHitOne;
        TWIN_HIT_BOTH: twinHit = e.twinHitBoth;
        default: twinHit = 1'b0;
      endcase
    end

    always_comb begin
      case (lvlCmp)
        CMP_GT: lvlHit = e.levelValid && (e.activeLevels > lvlThr);
        CMP_EQ: lvlHit = e.levelValid && (e.activeLevels == lvlThr);
        default: lvlHit = 1'b0;
      endcase
    end

    assign mcOk = ((e.msgClass ^ mcSel) & mcmSel) == 4'h0;
    assign ocOk = ((e.opcode ^ ocSel) & ocmSel) == 4'h0;
    assign node = (dirSel == DIR_IN) ? e.reqHomeNode : e.destNode;
    assign nodeOk = ((node ^ nidSel) & nidmSel) == 5'h0;

    always_comb begin
      case (dirSel)
        DIR_IN: dirHit = nodeOk;
        DIR_OUT: dirHit = nodeOk;
        DIR_TRK: dirHit = (e.trackerState == tosSel) && |(e.respType & torSel);
        DIR_LKP: dirHit = |(e.lookupStatus & lstSel);
        default: dirHit = 1'b0;
      endcase
    end

    assign twinHitV[i] = twinHit;
    assign lvlHitV[i] = lvlHit;
    assign accHitV[i] = e.accValid && (accSel != 3'h0) && (e.accType == accSel);
    assign trafHitV[i] = trafEn_q && e.trafValid && (e.trafDir == dirSel) && mcOk && ocOk
      && dirHit;
    assign agentHit[i] = twinHit | lvlHit | accHitV[i] | trafHitV[i];
  end

  // one pulse per clock, even if several agents hit together
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      countPulse_q <= 1'b0;
    end else begin
      countPulse_q <= |(agentHit & agentEn);
    end
  end
  assign countPulse = countPulse_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulseTotal_q <= 32'h0;
    end else if (countPulse_q) begin
      pulseTotal_q <= pulseTotal_q + 32'h1;
    end
  end

  // write side: both channels are taken in one cycle, so arrival order is free
  assign wrTake = axiReq.awvalid && axiReq.wvalid && !bvalid_q;
  assign rdTake = axiReq.arvalid && !rvalid_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    case (axiReq.awaddr[ADDR_W-1:2])
      REG_SEL_LO[ADDR_W-1:2], REG_SEL_MID[ADDR_W-1:2], REG_SEL_HI[ADDR_W-1:2],
      REG_CTRL[ADDR_W-1:2], REG_STAT[ADDR_W-1:2]: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_q <= SEL_RST;
    end else if (wrTake) begin
      case (axiReq.awaddr[ADDR_W-1:2])
        REG_SEL_LO[ADDR_W-1:2]: sel_q[31:0] <= merge(sel_q[31:0], axiReq.wdata, axiReq.wstrb);
        REG_SEL_MID[ADDR_W-1:2]: sel_q[63:32] <= merge(sel_q[63:32], axiReq.wdata,
          axiReq.wstrb);
        REG_SEL_HI[ADDR_W-1:2]: begin
          if (axiReq.wstrb[0]) begin
            sel_q[64] <= axiReq.wdata[0];
          end
        end
        default: sel_q <= sel_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      src_q <= SRC_RST;
      trafEn_q <= CTRL_TRAF_EN_RST;
    end else if (wrTake && axiReq.awaddr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) begin
      if (axiReq.wstrb[0]) begin
        src_q[7:0] <= axiReq.wdata[CTRL_SRC_LSB +: 8];
      end
      if (axiReq.wstrb[1]) begin
        src_q[8] <= axiReq.wdata[CTRL_SRC_LSB + 8];
        trafEn_q <= axiReq.wdata[CTRL_TRAF_EN_BIT];
      end
    end
  end

  // writes to the read-only total are accepted and dropped
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wrTake) begin
      bvalid_q <= 1'b1;
      bresp_q <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rdOk = 1'b1;
    case (axiReq.araddr[ADDR_W-1:2])
      REG_SEL_LO[ADDR_W-1:2]: rdWord = sel_q[31:0];
      REG_SEL_MID[ADDR_W-1:2]: rdWord = sel_q[63:32];
      REG_SEL_HI[ADDR_W-1:2]: rdWord = {31'h0, sel_q[64]};
      REG_CTRL[ADDR_W-1:2]: rdWord = {22'h0, trafEn_q, src_q};
      REG_STAT[ADDR_W-1:2]: rdWord = pulseTotal_q;
      default: begin
        rdWord = 32'h0;
        rdOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (rdTake) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdWord;
      rresp_q <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axiRsp.awready = wrTake;
  assign axiRsp.wready = wrTake;
  assign axiRsp.bvalid = bvalid_q;
  assign axiRsp.bresp = bresp_q;
  assign axiRsp.arready = !rvalid_q;
  assign axiRsp.rvalid = rvalid_q;
  assign axiRsp.rdata = rdata_q;
  assign axiRsp.rresp = rresp_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_pulse_from_hits: assert property (|(agentHit & agentEn) |=> countPulse)
    else $error("enabled agent hit not counted");
  a_no_spurious_pulse: assert property ((agentHit & agentEn) == 8'h00 |=> !countPulse)
    else $error("count pulse without an enabled agent hit");
  a_twin_miss_pulse: assert property (sel_q[9:7] == 3'h2 && agentEvt[0].twinMiss
    && agentEn[0] |=> countPulse)
    else $error("twin miss on agent 0 not counted");
  a_twin_decode: assert property (twinHitV[0] |->
    (twinSel == TWIN_LOOKUP && agentEvt[0].twinLookup)
    || (twinSel == TWIN_MISS && agentEvt[0].twinMiss)
    || (twinSel == TWIN_HIT_ONE && agentEvt[0].twinHitOne)
    || (twinSel == TWIN_HIT_BOTH && agentEvt[0].twinHitBoth))
    else $error("twin hit without matching twin code");
  a_level_compare: assert property (lvlHitV[2] |-> agentEvt[2].levelValid &&
    ((sel_q[11:10] == 2'h2) ? agentEvt[2].activeLevels == sel_q[16:12]
    : (sel_q[11:10] == 2'h1 && agentEvt[2].activeLevels > sel_q[16:12])))
    else $error("level hit without satisfied compare");
  a_level_gt_counts: assert property (sel_q[16:10] == 7'h31 && agentEn[2]
    && agentEvt[2].levelValid && agentEvt[2].activeLevels == 5'h0D |=> countPulse)
    else $error("level above twelve not counted");
  a_access_match: assert property (accHitV[0] |-> agentEvt[0].accValid
    && agentEvt[0].accType == sel_q[19:17] && sel_q[19:17] != 3'h0)
    else $error("access hit with wrong type");
  a_traffic_dir: assert property (trafHitV[0] |-> agentEvt[0].trafDir == sel_q[64:63]
    && trafEn_q)
    else $error("traffic hit in wrong direction");
  a_node_incoming: assert property (trafHitV[0] && dirSel == DIR_IN |->
    ((agentEvt[0].reqHomeNode ^ sel_q[46:42]) & sel_q[41:37]) == 5'h0)
    else $error("incoming requester node mismatch counted");
  a_node_outgoing: assert property (trafHitV[0] && dirSel == DIR_OUT |->
    ((agentEvt[0].destNode ^ sel_q[46:42]) & sel_q[41:37]) == 5'h0)
    else $error("outgoing destination node mismatch counted");
  a_class_masked: assert property (trafHitV[0] |->
    ((agentEvt[0].msgClass ^ sel_q[62:59]) & sel_q[58:55]) == 4'h0)
    else $error("message class mismatch counted");
  a_opcode_masked: assert property (trafHitV[0] |->
    ((agentEvt[0].opcode ^ sel_q[54:51]) & sel_q[50:47]) == 4'h0)
    else $error("opcode mismatch counted");
  a_tracker_resp: assert property (trafHitV[0] && dirSel == DIR_TRK |->
    agentEvt[0].trackerState == sel_q[31:30] && |(agentEvt[0].respType & sel_q[29:20]))
    else $error("tracker hit without state and response");
  a_lookup_status: assert property (trafHitV[0] && dirSel == DIR_LKP |->
    |(agentEvt[0].lookupStatus & sel_q[36:32]))
    else $error("lookup hit without selected status");
  a_local_only: assert property (src_q == SRC_LOCAL && agentHit[7:4] == 4'h0 |=>
    !countPulse)
    else $error("remote agent counted under local-only source");
  a_remote_only: assert property (src_q == SRC_REMOTE && agentHit[3:0] == 4'h0 |=>
    !countPulse)
    else $error("local agent counted under remote-only source");
  a_both_sources: assert property (src_q == SRC_BOTH && |agentHit |=> countPulse)
    else $error("agent hit not counted with both groups enabled");
  a_resp_after_write: assert property (wrTake |=> bvalid_q)
    else $error("write taken without response");
  a_total_follows: assert property (countPulse |=>
    pulseTotal_q == $past(pulseTotal_q) + 32'h1)
    else $error("pulse total not advanced by a pulse");
  a_read_top_bit: assert property (rdTake && sel_q[64]
    && axiReq.araddr[ADDR_W-1:2] == REG_SEL_HI[ADDR_W-1:2] |=> rdata_q == 32'h00000001)
    else $error("top select bit not returned on read");

  c_twin_pulse: cover property (twinHitV[0] && agentEn[0] ##1 countPulse);
  c_tracker_pulse: cover property (dirSel == DIR_TRK && |trafHitV ##1 countPulse);
  c_level_pulse: cover property (|lvlHitV ##1 countPulse);
  c_write_done: cover property (wrTake ##[1:4] bvalid_q && axiReq.bready);
  c_read_done: cover property (rdTake ##[1:4] rvalid_q && axiReq.rready);
endmodule
`default_nettype wire

// ==== include/cpe_pkg.sv ====
package cpe_pkg;
  localparam int NAGENT = 8;
  localparam int ADDR_W = 8;
  localparam int SEL_W = 65;
  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_SEL_LO = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SEL_MID = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SEL_HI = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
  // reset values
  localparam logic [SEL_W-1:0] SEL_RST = 65'h0;
  localparam logic [8:0] SRC_RST = 9'h1FE;
  localparam logic CTRL_TRAF_EN_RST = 1'b0;
  // event-select field positions
  localparam int TWIN_LSB = 7;
  localparam int LVL_CMP_LSB = 10;
  localparam int LVL_THR_LSB = 12;
  localparam int ACC_LSB = 17;
  localparam int TOR_LSB = 20;
  localparam int TOS_LSB = 30;
  localparam int LST_LSB = 32;
  localparam int NODE_IDENTIFIER_MASK_LSB = 37;
  localparam int NID_LSB = 42;
  localparam int OCM_LSB = 47;
  localparam int OC_LSB = 51;
  localparam int MCM_LSB = 55;
  localparam int MC_LSB = 59;
  localparam int DIR_LSB = 63;
  // control register field positions
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_TRAF_EN_BIT = 9;
  // twin-line codes
  localparam logic [2:0] TWIN_LOOKUP = 3'h1;
  localparam logic [2:0] TWIN_MISS = 3'h2;
  localparam logic [2:0] TWIN_HIT_ONE = 3'h3;
  localparam logic [2:0] TWIN_HIT_BOTH = 3'h4;
  // active-level compare codes
  localparam logic [1:0] CMP_GT = 2'h1;
  localparam logic [1:0] CMP_EQ = 2'h2;
  // directory access codes
  localparam logic [2:0] ACC_SRAM_UPD = 3'h1;
  localparam logic [2:0] ACC_SRAM_RD = 3'h2;
  localparam logic [2:0] ACC_IPT_UPD = 3'h3;
  localparam logic [2:0] ACC_IPT_RD = 3'h4;
  localparam logic [2:0] ACC_ELECTED = 3'h5;
  // traffic directions
  localparam logic [1:0] DIR_IN = 2'h0;
  localparam logic [1:0] DIR_OUT = 2'h1;
  localparam logic [1:0] DIR_TRK = 2'h2;
  localparam logic [1:0] DIR_LKP = 2'h3;
  // unit-source encodings
  localparam logic [8:0] SRC_BOTH = 9'h1FE;
  localparam logic [8:0] SRC_LOCAL = 9'h1E0;
  localparam logic [8:0] SRC_REMOTE = 9'h01E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } cpe_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpe_axi_rsp_t;

  typedef struct packed {
    logic twinLookup;
    logic twinMiss;
    logic twinHitOne;
    logic twinHitBoth;
    logic levelValid;
    logic [4:0] activeLevels;
    logic accValid;
    logic [2:0] accType;
    logic trafValid;
    logic [1:0] trafDir;
    logic [3:0] msgClass;
    logic [3:0] opcode;
    logic [4:0] reqHomeNode;
    logic [4:0] destNode;
    logic [4:0] lookupStatus;
    logic [1:0] trackerState;
    logic [9:0] respType;
  } cpe_agent_evt_t;
endpackage

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module tb_top;
  import cpe_pkg::*;
  logic clock;
  logic sys_rst;
  cpe_axi_req_t axiReq;
  cpe_axi_rsp_t axiRsp;
  cpe_agent_evt_t [NAGENT-1:0] agentEvt;
  logic countPulse;
  int errorCnt;
  int checks;
  int expTotal;
  logic [31:0] rdVal;
  logic [1:0] rdResp;
  cpe_agent_evt_t ev;

  cpe_event_select dut_u (.clock(clock), .sys_rst(sys_rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .agentEvt(agentEvt), .countPulse(countPulse));

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // address and data offered together; both readies rise in the same cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    axiReq.awaddr <= a;
    axiReq.awvalid <= 1'h1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'h1;
    axiReq.bready <= 1'h1;
    do @(posedge clock); while (!(axiRsp.awready && axiRsp.wready));
    axiReq.awvalid <= 1'h0;
    axiReq.wvalid <= 1'h0;
    do @(posedge clock); while (!axiRsp.bvalid);
    r = axiRsp.bresp;
    axiReq.bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'h1;
    axiReq.rready <= 1'h1;
    do @(posedge clock); while (!axiRsp.arready);
    axiReq.arvalid <= 1'h0;
    do @(posedge clock); while (!axiRsp.rvalid);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'h0;
  endtask

  task automatic setSel(input logic [64:0] v);
    wr(REG_SEL_LO, v[31:0], rdResp);
    wr(REG_SEL_MID, v[63:32], rdResp);
    wr(REG_SEL_HI, {31'h0, v[64]}, rdResp);
  endtask

  task automatic setCtrl(input logic en, input logic [8:0] src);
    wr(REG_CTRL, {22'h0, en, src}, rdResp);
  endtask

  // one hitting cycle, pulse looked at in the following cycle
  task automatic hit(input int ag, input cpe_agent_evt_t e, input logic exp);
    @(posedge clock);
    agentEvt[ag] <= e;
    @(posedge clock);
    agentEvt <= '0;
    #1;
    `CHK(countPulse, exp)
    if (exp) expTotal++;
  endtask

  task automatic lvl(input logic [4:0] l, input logic exp);
    ev = '0;
    ev.levelValid = 1'h1;
    ev.activeLevels = l;
    hit(2, ev, exp);
  endtask

  task automatic tr(input logic [1:0] d, input logic [3:0] mc, input logic [3:0] oc,
      input logic [4:0] rh, input logic [4:0] dn, input logic [4:0] ls,
      input logic [1:0] ts, input logic [9:0] rt, input logic exp);
    ev = '0;
    ev.trafValid = 1'h1;
    {ev.trafDir, ev.msgClass, ev.opcode, ev.reqHomeNode, ev.destNode} = {d, mc, oc, rh, dn};
    {ev.lookupStatus, ev.trackerState, ev.respType} = {ls, ts, rt};
    hit(0, ev, exp);
  endtask

  function automatic logic [64:0] tsel(logic [1:0] d, logic [3:0] mc, logic [3:0] message_class_mask,
      logic [3:0] oc, logic [3:0] opcode_mask, logic [4:0] node_identifier, logic [4:0] node_identifier_mask,
      logic [4:0] lookup_dir_status, logic [1:0] tracker_out_state, logic [9:0] tracker_resp_type);
    return (65'(d) << DIR_LSB) | (65'(mc) << MC_LSB) | (65'(message_class_mask) << MCM_LSB)
      | (65'(oc) << OC_LSB) | (65'(opcode_mask) << OCM_LSB) | (65'(node_identifier) << NID_LSB)
      | (65'(node_identifier_mask) << NODE_IDENTIFIER_MASK_LSB) | (65'(lookup_dir_status) << LST_LSB) | (65'(tracker_out_state) << TOS_LSB)
      | (65'(tracker_resp_type) << TOR_LSB);
  endfunction

  // hang guard: the whole sequence needs well under ten thousand cycles
  initial begin
    #500000;
    errorCnt++;
    tally_and_finish();
  end

  initial begin
    axiReq = '0;
    agentEvt = '0;
    ev = '0;
    sys_rst = 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    rd(REG_CTRL, rdVal, rdResp);
    `CHK(rdVal, {22'h0, CTRL_TRAF_EN_RST, SRC_RST})
    rd(8'h14, rdVal, rdResp);
    `CHK(rdResp, RESP_SLVERR)
    wr(8'h14, 32'hFFFFFFFF, rdResp);
    `CHK(rdResp, RESP_SLVERR)
    ev.twinLookup = 1'h1;
    hit(0, ev, 1'h0);
    for (int c = 1; c <= 4; c++) begin
      setSel(65'(c) << TWIN_LSB);
      ev = '0;
      {ev.twinLookup, ev.twinMiss, ev.twinHitOne, ev.twinHitBoth} = 4'h8 >> (c - 1);
      hit(0, ev, 1'h1);
      {ev.twinLookup, ev.twinMiss, ev.twinHitOne, ev.twinHitBoth} = ~(4'h8 >> (c - 1));
      hit(c, ev, 1'h0);
    end
    setSel((65'(5'h0C) << LVL_THR_LSB) | (65'(CMP_GT) << LVL_CMP_LSB));
    lvl(5'h0D, 1'h1);
    lvl(5'h0C, 1'h0);
    setSel((65'(5'h0C) << LVL_THR_LSB) | (65'(CMP_EQ) << LVL_CMP_LSB));
    lvl(5'h0C, 1'h1);
    lvl(5'h0D, 1'h0);
    for (int c = 1; c <= 5; c++) begin
      setSel(65'(c) << ACC_LSB);
      ev = '0;
      ev.accValid = 1'h1;
      ev.accType = 3'(c);
      hit(0, ev, 1'h1);
      ev.accType = (c == 5) ? 3'h1 : 3'(c + 1);
      hit(6, ev, 1'h0);
    end
    setCtrl(1'h1, SRC_BOTH);
    `CHK(rdResp, RESP_OKAY)
    setSel(tsel(DIR_IN, 4'h5, 4'hF, 4'h0, 4'h0, 5'h00, 5'h00, 5'h00, 2'h0, 10'h000));
    tr(DIR_IN, 4'h5, 4'h7, 5'h04, 5'h09, 5'h00, 2'h0, 10'h000, 1'h1);
    tr(DIR_IN, 4'h6, 4'h7, 5'h04, 5'h09, 5'h00, 2'h0, 10'h000, 1'h0);
    tr(DIR_OUT, 4'h5, 4'h7, 5'h04, 5'h09, 5'h00, 2'h0, 10'h000, 1'h0);
    setSel(tsel(DIR_IN, 4'h5, 4'hF, 4'h3, 4'hF, 5'h03, 5'h1F, 5'h00, 2'h0, 10'h000));
    tr(DIR_IN, 4'h5, 4'h3, 5'h03, 5'h09, 5'h00, 2'h0, 10'h000, 1'h1);
    tr(DIR_IN, 4'h5, 4'h2, 5'h03, 5'h09, 5'h00, 2'h0, 10'h000, 1'h0);
    tr(DIR_IN, 4'h5, 4'h3, 5'h04, 5'h03, 5'h00, 2'h0, 10'h000, 1'h0);
    setSel(tsel(DIR_OUT, 4'h5, 4'hF, 4'h0, 4'h0, 5'h09, 5'h1F, 5'h00, 2'h0, 10'h000));
    tr(DIR_OUT, 4'h5, 4'h1, 5'h00, 5'h09, 5'h00, 2'h0, 10'h000, 1'h1);
    tr(DIR_OUT, 4'h5, 4'h1, 5'h09, 5'h08, 5'h00, 2'h0, 10'h000, 1'h0);
    setSel(tsel(DIR_TRK, 4'h5, 4'hF, 4'h0, 4'h0, 5'h00, 5'h00, 5'h00, 2'h2, 10'h009));
    tr(DIR_TRK, 4'h5, 4'h1, 5'h00, 5'h00, 5'h00, 2'h2, 10'h008, 1'h1);
    tr(DIR_TRK, 4'h5, 4'h1, 5'h00, 5'h00, 5'h00, 2'h2, 10'h002, 1'h0);
    tr(DIR_TRK, 4'h5, 4'h1, 5'h00, 5'h00, 5'h00, 2'h1, 10'h001, 1'h0);
    setSel(tsel(DIR_LKP, 4'h5, 4'hF, 4'h0, 4'h0, 5'h00, 5'h00, 5'h03, 2'h0, 10'h000));
    rd(REG_SEL_HI, rdVal, rdResp);
    `CHK(rdVal, 32'h00000001)
    tr(DIR_LKP, 4'h5, 4'h1, 5'h00, 5'h00, 5'h02, 2'h0, 10'h000, 1'h1);
    tr(DIR_LKP, 4'h5, 4'h1, 5'h00, 5'h00, 5'h10, 2'h0, 10'h000, 1'h0);
    setSel(65'(TWIN_MISS) << TWIN_LSB);
    ev = '0;
    ev.twinMiss = 1'h1;
    setCtrl(1'h0, SRC_LOCAL);
    hit(2, ev, 1'h0);
    hit(6, ev, 1'h1);
    setCtrl(1'h0, SRC_REMOTE);
    hit(2, ev, 1'h1);
    hit(6, ev, 1'h0);
    setCtrl(1'h0, SRC_BOTH);
    // two agents over two cycles: one pulse per cycle, not per agent
    @(posedge clock);
    agentEvt[7] <= ev;
    agentEvt[0] <= ev;
    @(posedge clock);
    #1 `CHK(countPulse, 1'h1)
    @(posedge clock);
    agentEvt <= '0;
    #1 `CHK(countPulse, 1'h1)
    @(posedge clock);
    #1 `CHK(countPulse, 1'h0)
    expTotal += 2;
    // the total is read-only: a write is answered but must leave it alone
    wr(REG_STAT, 32'h00000055, rdResp);
    `CHK(rdResp, RESP_OKAY)
    rd(REG_STAT, rdVal, rdResp);
    `CHK(rdVal, 32'(expTotal))
    tally_and_finish();
  end
endmodule
`default_nettype wire
